// [verilog/ogm_regs.sv]
// register bank: gain code and silence bit for output paths 2 and 3
// assumes synchronous inputs on clk; read data one cycle after rd
// Notes on behaviour
// - each channel has a silence bit at bit 8, 1 silences, reset to 1.
// - each channel holds an 8-bit gain code in bits 7 to 0.
// - code 0x00 is -64 dB, 0x80 is 0 dB, 0xbf is +31.5 dB, 0.5 dB per step.
// - each gain code resets to 0x80.
// - writing 1 to bit 9 of any channel applies all staged settings at once.
// - the commit bit is write-only and reads as zero.
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
module ogm_regs
  import ogm_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  input  wire ogm_pkg::ogm_bus_req_t bus_req,
  output logic [15:0]               rdata,
  output ogm_pkg::ogm_chan_t        path2_left,
  output ogm_pkg::ogm_chan_t        path2_right,
  output ogm_pkg::ogm_chan_t        path3_left,
  output ogm_pkg::ogm_chan_t        path3_right
);
  import ogm_pkg::*;

  ogm_chan_t  staged_q  [NUM_CH];
  ogm_chan_t  applied_q [NUM_CH];
  logic [3:0] hit;
  logic       any_hit;
  logic       commit;
  logic [1:0] sel;
  ogm_chan_t  wr_val;
  ogm_chan_t  rd_val;

  always_comb begin
    hit[0] = (bus_req.addr == OFS_OUT2_LEFT);
    hit[1] = (bus_req.addr == OFS_OUT2_RIGHT);
    hit[2] = (bus_req.addr == OFS_OUT3_LEFT);
    hit[3] = (bus_req.addr == OFS_OUT3_RIGHT);
  end

  assign any_hit = |hit;

  always_comb begin
    case (1'b1)
      hit[1]:  sel = 2'h1;
      hit[2]:  sel = 2'h2;
      hit[3]:  sel = 2'h3;
      default: sel = 2'h0;
    endcase
  end

  // gain codes are stored as written; reserved codes are software's to avoid
  always_comb begin
    wr_val.silence   = bus_req.wdata[SILENCE_BIT];
    wr_val.gain_code = bus_req.wdata[GAIN_MSB:GAIN_LSB];
  end

  // commit from any channel address, carried by the same write
  assign commit = bus_req.wr && any_hit && bus_req.wdata[COMMIT_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        staged_q[i].silence   <= SILENCE_RESET;
        staged_q[i].gain_code <= GAIN_RESET;
      end
    end else if (clk_en && bus_req.wr) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (hit[i]) begin
          staged_q[i] <= wr_val;
        end
      end
    end
  end

  // applied set takes the staged values including the committing write
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        applied_q[i].silence   <= SILENCE_RESET;
        applied_q[i].gain_code <= GAIN_RESET;
      end
    end else if (clk_en && commit) begin
      for (int i = 0; i < NUM_CH; i++) begin
        applied_q[i] <= hit[i] ? wr_val : staged_q[i];
      end
    end
  end

  always_comb begin
    rd_val = staged_q[sel];
  end

  // commit bit is never stored so bit 9 and above always read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (clk_en) begin
      if (bus_req.rd && any_hit) begin
        rdata <= {7'h00, rd_val};
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  assign path2_left  = applied_q[0];
  assign path2_right = applied_q[1];
  assign path3_left  = applied_q[2];
  assign path3_right = applied_q[3];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_silence_on: assert property (
    $past(rst) |-> path2_left.silence && path3_right.silence)
    else $error("silence not set after reset");

  a_reset_gain_unity: assert property (
    $past(rst) |-> path2_right.gain_code == GAIN_UNITY_CODE)
    else $error("gain not unity after reset");

  a_commit_applies_all: assert property (
    clk_en && bus_req.wr && hit[2] && bus_req.wdata[COMMIT_BIT]
    |=> path3_left == $past(wr_val) && path2_left == $past(staged_q[0]))
    else $error("commit did not apply staged values");

  a_no_commit_holds: assert property (
    !(clk_en && commit) |=> $stable(path2_left) && $stable(path3_right))
    else $error("applied value changed without commit");

  a_read_staged_back: assert property (
    clk_en && bus_req.rd && hit[1]
    |=> rdata[8:0] == $past(staged_q[1]))
    else $error("read did not return staged value");

  a_commit_reads_zero: assert property (
    clk_en && bus_req.rd |=> rdata[15:9] == 7'h00)
    else $error("commit bit read back nonzero");

  a_gain_field_write: assert property (
    clk_en && bus_req.wr && hit[3]
    |=> staged_q[3].gain_code == $past(bus_req.wdata[7:0]))
    else $error("gain code not staged");

  a_silence_field_write: assert property (
    clk_en && bus_req.wr && hit[0]
    |=> staged_q[0].silence == $past(bus_req.wdata[8]))
    else $error("silence bit not staged");

  // reset values on every applied channel, and on the staged value of path 3 left
  a_reset_silence_p2r: assert property (
    $past(rst)
    |-> path2_right.silence == SILENCE_RESET)
    else $error("path 2 right not silenced after reset");

  a_reset_silence_p3l: assert property (
    $past(rst)
    |-> path3_left.silence == SILENCE_RESET)
    else $error("path 3 left not silenced after reset");

  a_reset_gain_p2l: assert property (
    $past(rst)
    |-> path2_left.gain_code == GAIN_RESET)
    else $error("path 2 left gain not reset");

  a_reset_gain_p3l: assert property (
    $past(rst)
    |-> path3_left.gain_code == GAIN_RESET)
    else $error("path 3 left gain not reset");

  a_reset_gain_p3r: assert property (
    $past(rst)
    |-> path3_right.gain_code == GAIN_RESET)
    else $error("path 3 right gain not reset");

  a_reset_staged_p3l: assert property (
    $past(rst)
    |-> staged_q[2] == {SILENCE_RESET, GAIN_RESET})
    else $error("staged value not reset");

  a_reset_rdata_zero: assert property (
    $past(rst)
    |-> rdata == 16'h0000)
    else $error("read data not cleared by reset");

  // a commit copies the other channels' staged values unchanged
  a_commit_p2r_other: assert property (
    clk_en && commit && !hit[1]
    |=> path2_right == $past(staged_q[1]))
    else $error("path 2 right missed the commit");

  a_commit_p3l_other: assert property (
    clk_en && commit && !hit[2]
    |=> path3_left == $past(staged_q[2]))
    else $error("path 3 left missed the commit");

  a_commit_p3r_other: assert property (
    clk_en && commit && !hit[3]
    |=> path3_right == $past(staged_q[3]))
    else $error("path 3 right missed the commit");

  a_commit_own_p2l: assert property (
    clk_en && commit && hit[0]
    |=> path2_left == $past(bus_req.wdata[SILENCE_BIT:GAIN_LSB]))
    else $error("committing word not applied on path 2 left");

  a_commit_own_p3r: assert property (
    clk_en && commit && hit[3]
    |=> path3_right == $past(bus_req.wdata[SILENCE_BIT:GAIN_LSB]))
    else $error("committing word not applied on path 3 right");

  a_commit_silence_p3l: assert property (
    clk_en && commit && hit[2]
    |=> path3_left.silence == $past(bus_req.wdata[SILENCE_BIT]))
    else $error("silence not applied by commit");

  a_hold_p2r: assert property (
    !(clk_en && commit)
    |=> $stable(path2_right))
    else $error("path 2 right changed without commit");

  a_hold_p3l: assert property (
    !(clk_en && commit)
    |=> $stable(path3_left))
    else $error("path 3 left changed without commit");

  // a low enable must freeze every piece of state
  a_freeze_staged: assert property (
    !clk_en
    |=> $stable(staged_q[0]) && $stable(staged_q[3]))
    else $error("staged value moved while disabled");

  a_freeze_applied: assert property (
    !clk_en
    |=> $stable(path3_left) && $stable(path2_right))
    else $error("applied value moved while disabled");

  a_freeze_rdata: assert property (
    !clk_en
    |=> $stable(rdata))
    else $error("read data moved while disabled");

  a_read_p2l: assert property (
    clk_en && bus_req.rd && hit[0]
    |=> rdata[8:0] == $past(staged_q[0]))
    else $error("path 2 left read wrong");

  a_read_p3l: assert property (
    clk_en && bus_req.rd && hit[2]
    |=> rdata[8:0] == $past(staged_q[2]))
    else $error("path 3 left read wrong");

  a_read_p3r: assert property (
    clk_en && bus_req.rd && hit[3]
    |=> rdata[8:0] == $past(staged_q[3]))
    else $error("path 3 right read wrong");

  a_read_unmapped: assert property (
    clk_en && bus_req.rd && !any_hit
    |=> rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_idle_rdata: assert property (
    clk_en && !bus_req.rd
    |=> rdata == 16'h0000)
    else $error("read data held past its cycle");

  a_stage_p2r: assert property (
    clk_en && bus_req.wr && hit[1]
    |=> staged_q[1] == $past(bus_req.wdata[SILENCE_BIT:GAIN_LSB]))
    else $error("path 2 right not staged");

  a_stage_p3l: assert property (
    clk_en && bus_req.wr && hit[2]
    |=> staged_q[2] == $past(bus_req.wdata[SILENCE_BIT:GAIN_LSB]))
    else $error("path 3 left not staged");

  a_unmapped_write: assert property (
    clk_en && bus_req.wr && !any_hit
    |=> $stable(staged_q[0]) && $stable(staged_q[1]))
    else $error("unmapped write changed a channel");

  a_no_write_staged: assert property (
    !(clk_en && bus_req.wr)
    |=> $stable(staged_q[1]) && $stable(staged_q[2]))
    else $error("staged value changed without a write");

  c_commit_write: cover property (clk_en && commit);
  c_unmute_applied: cover property (commit ##1 !path2_left.silence);
  c_max_gain: cover property (path3_right.gain_code == GAIN_MAX_CODE);
  c_freeze_write: cover property (!clk_en && bus_req.wr);
  c_stage_then_commit: cover property (
    bus_req.wr && !commit ##[1:4] commit);

endmodule : ogm_regs

// [inc/ogm_pkg.sv]
// package for the output path 2/3 gain and silence register bank
// assumes a plain register port with word addresses as printed
package ogm_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;

  // register offsets
  localparam logic [11:0] OFS_OUT2_LEFT  = 12'h419;
  localparam logic [11:0] OFS_OUT2_RIGHT = 12'h41d;
  localparam logic [11:0] OFS_OUT3_LEFT  = 12'h421;
  localparam logic [11:0] OFS_OUT3_RIGHT = 12'h425;

  // field positions
  localparam int unsigned GAIN_LSB    = 0;
  localparam int unsigned GAIN_MSB    = 7;
  localparam int unsigned SILENCE_BIT = 8;
  localparam int unsigned COMMIT_BIT  = 9;

  // reset values
  localparam logic [7:0] GAIN_RESET    = 8'h80;
  localparam logic       SILENCE_RESET = 1'b1;

  // gain code landmarks
  localparam logic [7:0] GAIN_MIN_CODE   = 8'h00;
  localparam logic [7:0] GAIN_UNITY_CODE = 8'h80;
  localparam logic [7:0] GAIN_MAX_CODE   = 8'hbf;

  localparam int unsigned NUM_CH = 4;

  typedef struct packed {
    logic       silence;
    logic [7:0] gain_code;
  } ogm_chan_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ogm_bus_req_t;

endpackage : ogm_pkg

// [tb/testbench.sv]
// self-checking bench for the output path 2/3 gain and silence registers
// assumes the design checks its own timing through its inline assertions
`timescale 1ns/10ps
module testbench;
  import ogm_pkg::*;
  logic         clk;
  logic         rst;
  logic         clk_en;
  ogm_bus_req_t bus_req;
  logic [15:0]  rdata;
  ogm_chan_t    p2l, p2r, p3l, p3r;
  int           n_mismatch;
  int           n_compared;

  ogm_regs dut (
    .clk         (clk),
    .rst         (rst),
    .clk_en      (clk_en),
    .bus_req     (bus_req),
    .rdata       (rdata),
    .path2_left  (p2l),
    .path2_right (p2r),
    .path3_left  (p3l),
    .path3_right (p3r)
  );

  always #50 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_out(input logic [35:0] exp);
    chk({7'h0, p2l}, {7'h0, exp[35:27]});
    chk({7'h0, p2r}, {7'h0, exp[26:18]});
    chk({7'h0, p3l}, {7'h0, exp[17:9]});
    chk({7'h0, p3r}, {7'h0, exp[8:0]});
  endtask : chk_out

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // read data is registered, so it is looked at just after the next edge
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // the whole sequence needs well under 100 cycles
  initial begin
    #(400 * 100);
    n_mismatch++;
    end_sim;
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    bus_req = '0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1 chk_out({4{9'h180}});
    rd(OFS_OUT2_LEFT, 16'h0180);
    rd(OFS_OUT2_RIGHT, 16'h0180);
    rd(OFS_OUT3_LEFT, 16'h0180);
    rd(OFS_OUT3_RIGHT, 16'h0180);
    // stage without commit: min code and a max code, outputs unchanged
    wr(OFS_OUT3_LEFT, 16'h0000);
    wr(OFS_OUT2_RIGHT, {8'h0, GAIN_MAX_CODE});
    wr(OFS_OUT3_RIGHT, 16'h0155);
    rd(OFS_OUT3_LEFT, 16'h0000);
    rd(OFS_OUT2_RIGHT, 16'h00bf);
    chk_out({4{9'h180}});
    // commit through a different channel applies every staged value
    wr(OFS_OUT2_LEFT, 16'h027f);
    #1 chk_out({9'h07f, 9'h0bf, 9'h000, 9'h155});
    rd(OFS_OUT2_LEFT, 16'h007f);
    // unmapped address reads zero and a write there changes nothing
    wr(12'h411, 16'h0201);
    rd(12'h411, 16'h0000);
    chk_out({9'h07f, 9'h0bf, 9'h000, 9'h155});
    // commit through path 3 left also stages its own word
    wr(OFS_OUT3_LEFT, 16'h0300);
    #1 chk_out({9'h07f, 9'h0bf, 9'h100, 9'h155});
    rd(OFS_OUT3_LEFT, 16'h0100);
    // low enable drops requests and freezes everything
    @(posedge clk);
    clk_en <= 1'b0;
    wr(OFS_OUT2_RIGHT, 16'h0280);
    rd(OFS_OUT2_RIGHT, 16'h0000);
    chk_out({9'h07f, 9'h0bf, 9'h100, 9'h155});
    @(posedge clk);
    clk_en <= 1'b1;
    rd(OFS_OUT2_RIGHT, 16'h00bf);
    // a reset in mid-run restores every default
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1 chk_out({4{9'h180}});
    rd(OFS_OUT3_RIGHT, 16'h0180);
    end_sim;
  end
endmodule : testbench
